//--- dv/spi_master_slave_port_test.sv
`timescale 1ns/10ps
module spi_master_slave_port_test;
  import spi_port_pkg::*;
  logic       clk;
  logic       rst_n;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       pie;
  logic       gie;
  logic       irq;
  pin_bus_t   pout;
  pin_bus_t   poe;
  pin_bus_t   pdrv;
  pin_bus_t   line;
  logic       cpol;
  logic       cpha;
  logic [7:0] last;
  logic [7:0] got;
  int         err_count;
  int         checks_done;
  int         seed;
  int         i;

  // Each pin resolves from its enable, so a released device pin shows the peer.
  assign line = (poe & pout) | (~poe & pdrv);

  spi_port uut (
    .MCLK          (clk),
    .RST_N         (rst_n),
    .BUS_REQ       (req),
    .RDATA         (rdata),
    .PORT_IRQ_EN   (pie),
    .GLOBAL_IRQ_EN (gie),
    .IRQ           (irq),
    .PIN_IN        (line),
    .PIN_OUT       (pout),
    .PIN_OE        (poe)
  );
  spi_peer peer (.line(line), .cpol(cpol), .cpha(cpha), .drv(pdrv));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, d, e);
  endtask

  task automatic wait_flag(input int b);
    logic [7:0] f;
    f = 8'h00;
    for (int k = 0; k < 900 && f[b] !== 1'b1; k++) rd(ADDR_FLAGS, f);
    chk("flag wait", {7'h00, f[b]}, 8'h01);
  endtask

  function automatic logic [7:0] rev(input logic [7:0] v, input logic on);
    for (int k = 0; k < 8; k++) rev[k] = on ? v[7 - k] : v[k];
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Mode bits: 0 polarity, 1 phase, 2 low bit first; the rate follows bits 1:0.
  task automatic mtest(input logic [7:0] tx, input logic [7:0] pt, input logic [2:0] m, input logic coll);
    logic [7:0] c;
    c    = {2'b10, m[2], 1'b1, m[0], m[1], m[1:0]};
    cpol = m[0];
    cpha = m[1];
    peer.load(pt);
    wr(ADDR_FLAGS, 8'h08);
    wr(ADDR_CTRL, c);
    wr(ADDR_CTRL, c | 8'h40);
    wr(ADDR_DATA, tx);
    repeat (20) @(posedge clk);
    chk("auto select", {7'h00, line.ss_n}, 8'h00);
    if (coll) wr(ADDR_DATA, ~tx);
    wait_flag(FLG_TC);
    last = rev(pt, m[2]);
    rchk("rx byte", ADDR_DATA, last);
    rchk("flags", ADDR_FLAGS, {1'b1, coll, 6'h08});
    chk("peer rx", peer.sr, rev(tx, m[2]));
    chk("edges", {3'h0, peer.edges}, 8'h10);
    chk("idle sck", {7'h00, line.sck}, {7'h00, m[0]});
    chk("idle select", {7'h00, line.ss_n}, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
  endtask

  task automatic stest(input logic [7:0] tx, input logic [7:0] pt, input logic [2:0] m);
    logic [7:0] c;
    c    = {2'b00, m[2], 1'b0, m[0], m[1], 2'b00};
    cpol = m[0];
    cpha = m[1];
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL, c);
    wr(ADDR_CTRL, c | 8'h40);
    wr(ADDR_DATA, tx);
    #1 peer.xfer(pt, got);
    repeat (4) @(posedge clk);
    rchk("slave rx", ADDR_DATA, rev(pt, m[2]));
    rchk("slave flags", ADDR_FLAGS, 8'h80);
    chk("slave tx", got, rev(tx, m[2]));
    if (!m[1]) begin
      peer.sel(1'b0);
      repeat (4) @(posedge clk);
      wr(ADDR_DATA, 8'ha5);
      rchk("slave collision", ADDR_FLAGS, 8'hc0);
      peer.sel(1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    summarize();
  end

  initial begin
    err_count   = 0;
    checks_done = 0;
    seed        = 25459;
    rst_n       = 1'b0;
    req         = '0;
    pie         = 1'b1;
    gie         = 1'b1;
    cpol        = 1'b0;
    cpha        = 1'b0;
    last        = 8'h00;
    got         = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk("ctrl reset", ADDR_CTRL, CTRL_RESET);
    rchk("flags reset", ADDR_FLAGS, 8'h00);
    rchk("data reset", ADDR_DATA, DATA_RESET);
    rchk("unmapped", 8'h10, 8'h00);
    chk("oe reset", {4'h0, poe}, 8'h00);
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      mtest(8'($random(seed)), 8'($random(seed)), 3'(i), i == 3);
      $display("master case %0d done", i);
    end
    peer.load(8'h5a);
    wr(ADDR_DATA, 8'h3c);
    wait_flag(FLG_OVF);
    rchk("kept byte", ADDR_DATA, last);
    rchk("overrun", ADDR_FLAGS, 8'ha8);
    @(posedge clk) gie <= 1'b0;
    repeat (3) @(posedge clk);
    chk("masked irq", {7'h00, irq}, 8'h00);
    gie <= 1'b1;
    wr(ADDR_FLAGS, 8'h08);
    repeat (3) @(posedge clk);
    chk("cleared irq", {7'h00, irq}, 8'h00);
    $display("overrun test done");
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_CTRL, 8'h50);
    #1 peer.sel(1'b0);
    repeat (8) @(posedge clk);
    rchk("fault ctrl", ADDR_CTRL, 8'h00);
    rchk("fault flag", ADDR_FLAGS, 8'h10);
    chk("fault irq", {7'h00, irq}, 8'h01);
    peer.sel(1'b1);
    $display("mode fault test done");
    wr(ADDR_FLAGS, 8'h08);
    wr(ADDR_CTRL, 8'hd0);
    wr(ADDR_DATA, 8'h77);
    repeat (30) @(posedge clk);
    wr(ADDR_CTRL, 8'hd8);
    repeat (300) @(posedge clk);
    rchk("abort flags", ADDR_FLAGS, 8'h08);
    $display("abort test done");
    for (i = 0; i < 8; i++) begin
      stest(8'($random(seed)), 8'($random(seed)), 3'(i));
      $display("slave case %0d done", i);
    end
    summarize();
  end
endmodule

//--- dv/spi_peer.sv
`timescale 1ns/10ps
module spi_peer (
  input  spi_port_pkg::pin_bus_t line,
  input  logic                   cpol,
  input  logic                   cpha,
  output spi_port_pkg::pin_bus_t drv
);
  import spi_port_pkg::*;
  logic [7:0] sr;
  logic [4:0] edges;
  logic       drive;

  initial begin
    drv   = 4'b0100;
    sr    = 8'h00;
    edges = 5'h00;
    drive = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slave role: sample on the phase-selected edge, shift out on the other one.
  always @(line.sck) begin
    if (!drive && !line.ss_n) begin
      edges = edges + 5'h01;
      if (line.sck ^ cpol ^ cpha) sr = {sr[6:0], line.mosi};
      else drv.miso = sr[7];
    end
  end

  always @(negedge line.ss_n) begin
    edges    = 5'h00;
    drv.miso = sr[7];
  end

  // A released data line shows the inverse of its last bit, so no stale value passes.
  always @(posedge line.ss_n) drv.miso = ~drv.miso;

  task automatic load(input logic [7:0] b);
    sr = b;
  endtask

  task automatic sel(input logic v);
    drv.ss_n = v;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Master role: the clock stands at its idle level outside the byte.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    drive    = 1'b1;
    sr       = tx;
    drv.sck  = cpol;
    drv.mosi = tx[7];
    #64 drv.ss_n = 1'b0;
    #64;
    repeat (16) begin
      drv.sck = ~drv.sck;
      if (drv.sck ^ cpol ^ cpha) sr = {sr[6:0], line.miso};
      else drv.mosi = sr[7];
      #16;
    end
    #48 drv.ss_n = 1'b1;
    drv.mosi = ~drv.mosi;
    rx       = sr;
    drive    = 1'b0;
  endtask
endmodule

//--- verilog/spi_port.sv
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
// What this block does
// - Master-select bit chooses master or slave role.
// - Master data write shifts byte out, in.
// - After eight bits: stop clock, flag, buffer.
// - Master data write starts clocking immediately.
// - Slave select high mid-byte aborts, fills ones.
// - Slave byte copied to buffer, flag set.
// - Polarity sets idle level, phase sampling edge.
// - Phase zero slave drives bit on select.
// - Phase zero slave write while selected collides.
// - Phase one slave drives on first edge.
// - Change to control bits 5:0 while enabled aborts to idle.
// - Master without disable watches select for fault.
// - Auto select, with fault detect disabled, drives low during each transfer.
// - Select released when auto select off.
// - Fault clears master, enable; sets fault flag.
// - Busy data write flags collision, discards byte.
// - Uncleared complete flag then new byte sets overrun.
// - Overrun keeps old byte, drops new one.
// - Interrupt on complete, overrun or fault flag (not collision) when both enables set.
// - Event flags stay until software clears them.
// - Low-bit-first control reverses shift order.
// - Master drives exactly eight clock cycles.
module spi_port (
  input  logic                    MCLK,
  input  logic                    RST_N,
  input  spi_port_pkg::reg_req_t  BUS_REQ,
  output logic [7:0]              RDATA,
  input  logic                    PORT_IRQ_EN,
  input  logic                    GLOBAL_IRQ_EN,
  output logic                    IRQ,
  input  spi_port_pkg::pin_bus_t  PIN_IN,
  output spi_port_pkg::pin_bus_t  PIN_OUT,
  output spi_port_pkg::pin_bus_t  PIN_OE
);
  import spi_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
    out_bit = lsb ? sh[0] : sh[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // Bits not yet received are forced high; the received ones stay put.
  function automatic logic [7:0] fill_ones(input logic [7:0] sh, input logic [2:0] k, input logic lsb);
    fill_ones = lsb ? (sh | (8'hff >> k)) : (sh | (8'hff << k));
  endfunction

  // Half period in cycles minus one: rate 0 gives a clock of MCLK/16.
  function automatic logic [6:0] half_cycles(input logic [1:0] rate);
    half_cycles = (HALF_BASE << rate) - 7'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  pin_bus_t    pin_s;
  port_state_t s;
  port_state_t n;

  spi_sync2 #(
    .W    (4),
    .INIT (4'h4)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (PIN_IN),
    .q     (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  logic       wr_data;
  logic       wr_ctrl;
  logic       wr_flags;
  logic       sck_edge;
  logic       ss_fall;
  logic       master_on;
  logic       slave_on;
  logic       busy;
  logic       collide;
  logic       m_start;
  logic       half_hit;
  logic       fault;
  logic       cfg_abort;
  logic       edge_go;
  logic       in_bit;
  logic       drv;
  logic       drv_ok;
  logic       done;
  logic [7:0] rx_byte;

  always_comb begin
    n         = s;
    wr_data   = BUS_REQ.wr && (BUS_REQ.addr == ADDR_DATA);
    wr_ctrl   = BUS_REQ.wr && (BUS_REQ.addr == ADDR_CTRL);
    wr_flags  = BUS_REQ.wr && (BUS_REQ.addr == ADDR_FLAGS);
    sck_edge  = pin_s.sck ^ s.sck_prev;
    ss_fall   = s.ss_prev & ~pin_s.ss_n;
    master_on = s.ctrl.en & s.ctrl.mst;
    slave_on  = s.ctrl.en & ~s.ctrl.mst;
    busy      = s.st != ST_IDLE;
    collide   = wr_data & (busy | (slave_on & ~s.ctrl.cpha & ~pin_s.ss_n));
    m_start   = wr_data & ~collide & master_on;
    half_hit  = s.div_cnt == half_cycles(s.ctrl.rate);
    fault     = master_on & ~s.flags.mfd & ~pin_s.ss_n;
    cfg_abort = wr_ctrl & s.ctrl.en & (BUS_REQ.wdata[5:0] != s.ctrl[5:0]);
    edge_go   = 1'b0;
    in_bit    = 1'b0;
    drv       = 1'b0;
    drv_ok    = 1'b0;
    done      = 1'b0;
    rx_byte   = s.shifter;

    n.sck_prev = pin_s.sck;
    n.ss_prev  = pin_s.ss_n;

    // Reads have no side effect; the answer stands for one cycle only.
    n.rdata = 8'h00;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        ADDR_DATA:  n.rdata = s.rbuf;
        ADDR_CTRL:  n.rdata = s.ctrl;
        ADDR_FLAGS: n.rdata = {s.flags, 3'b000};
        default:    n.rdata = 8'h00;
      endcase
    end

    // Writing a zero clears an event flag; a one leaves it alone.
    if (wr_flags) begin
      n.flags.tc   = s.flags.tc & BUS_REQ.wdata[FLG_TC];
      n.flags.write_collision_flag = s.flags.write_collision_flag & BUS_REQ.wdata[FLG_WRITE_COLLISION_FLAG];
      n.flags.ovf  = s.flags.ovf & BUS_REQ.wdata[FLG_OVF];
      n.flags.mode_fault_flag = s.flags.mode_fault_flag & BUS_REQ.wdata[FLG_MODE_FAULT_FLAG];
      n.flags.mfd  = BUS_REQ.wdata[FLG_MFD];
    end
    if (collide) begin
      n.flags.write_collision_flag = 1'b1;
    end
    if (wr_ctrl) begin
      n.ctrl = ctrl_t'(BUS_REQ.wdata);
    end
    // A colliding byte never reaches the shifter.
    if (wr_data && !collide) begin
      n.shifter = BUS_REQ.wdata;
    end

    unique case (s.st)
      ST_IDLE: begin
        n.div_cnt  = 7'h00;
        n.edge_cnt = 4'h0;
        if (m_start) begin
          n.st = ST_MASTER;
          if (!s.ctrl.cpha) begin
            n.pout.mosi = out_bit(BUS_REQ.wdata, s.ctrl.lsb);
          end
        end else if (slave_on && !pin_s.ss_n) begin
          if (!s.ctrl.cpha && ss_fall) begin
            n.st        = ST_SLAVE;
            n.pout.miso = out_bit(s.shifter, s.ctrl.lsb);
          end else if (s.ctrl.cpha && sck_edge) begin
            n.st        = ST_SLAVE;
            n.edge_cnt  = 4'h1;
            n.pout.miso = out_bit(s.shifter, s.ctrl.lsb);
          end
        end
      end
      ST_MASTER: begin
        n.div_cnt = s.div_cnt + 7'h01;
        if (half_hit) begin
          n.div_cnt = 7'h00;
          n.sck     = ~s.sck;
          edge_go   = 1'b1;
          in_bit    = pin_s.miso;
        end
      end
      ST_SLAVE: begin
        if (pin_s.ss_n) begin
          n.st      = ST_IDLE;
          n.shifter = fill_ones(s.shifter, s.edge_cnt[3:1], s.ctrl.lsb);
        end else if (sck_edge) begin
          edge_go = 1'b1;
          in_bit  = pin_s.mosi;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Even edges lead a bit, odd edges trail it.
    if (edge_go) begin
      n.edge_cnt = s.edge_cnt + 4'h1;
      if (!s.edge_cnt[0]) begin
        if (!s.ctrl.cpha) begin
          n.rx_bit = in_bit;
        end else begin
          drv    = out_bit(s.shifter, s.ctrl.lsb);
          drv_ok = 1'b1;
        end
      end else begin
        n.shifter = shift_in(s.shifter, s.ctrl.cpha ? in_bit : s.rx_bit, s.ctrl.lsb);
        if (!s.ctrl.cpha) begin
          drv    = out_bit(n.shifter, s.ctrl.lsb);
          drv_ok = 1'b1;
        end
      end
      if (s.edge_cnt == LAST_EDGE) begin
        done    = 1'b1;
        n.st    = ST_IDLE;
        rx_byte = n.shifter;
      end
    end
    if (drv_ok) begin
      if (s.st == ST_MASTER) begin
        n.pout.mosi = drv;
      end else begin
        n.pout.miso = drv;
      end
    end

    // A completion sets its flag after any clear of the same cycle.
    if (done) begin
      n.flags.tc = 1'b1;
      if (s.flags.tc) begin
        n.flags.ovf = 1'b1;
      end else begin
        n.rbuf = rx_byte;
      end
    end

    if (cfg_abort) begin
      n.st = ST_IDLE;
    end
    if (fault) begin
      n.ctrl.mst   = 1'b0;
      n.ctrl.en    = 1'b0;
      n.flags.mode_fault_flag = 1'b1;
      n.st         = ST_IDLE;
    end
    if (!n.ctrl.en) begin
      n.st = ST_IDLE;
    end
    if (n.st != ST_MASTER) begin
      n.sck     = n.ctrl.cpol;
      n.div_cnt = 7'h00;
    end

    // Pins follow the next state; select is held one cycle past the last edge so the peer still sees it low.
    n.poe.sck   = n.ctrl.en & n.ctrl.mst;
    n.poe.mosi  = n.ctrl.en & n.ctrl.mst;
    n.poe.miso  = n.ctrl.en & ~n.ctrl.mst & ~pin_s.ss_n;
    n.poe.ss_n  = n.ctrl.en & n.ctrl.mst & n.flags.mfd & n.ctrl.soe;
    n.pout.sck  = n.sck;
    n.pout.ss_n = (n.st != ST_MASTER) && (s.st != ST_MASTER);
    n.irq       = PORT_IRQ_EN & GLOBAL_IRQ_EN & (n.flags.tc | n.flags.ovf | n.flags.mode_fault_flag);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.ctrl     <= ctrl_t'(CTRL_RESET);
      s.flags    <= flags_t'(FLAGS_RESET);
      s.shifter  <= DATA_RESET;
      s.rbuf     <= DATA_RESET;
      s.ss_prev  <= 1'b1;
      s.pout     <= 4'h4;
    end else begin
      s <= n;
    end
  end

  assign RDATA   = s.rdata;
  assign IRQ     = s.irq;
  assign PIN_OUT = s.pout;
  assign PIN_OE  = s.poe;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [4:0] tog_cnt;

  always_ff @(posedge MCLK) begin
    if (!RST_N || m_start) begin
      tog_cnt <= 5'h00;
    end else if (s.st == ST_MASTER && half_hit) begin
      tog_cnt <= tog_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_master_start;
    m_start && !fault && !cfg_abort;
  endsequence

  sequence s_master_running;
    s.st == ST_MASTER && PIN_OE.sck;
  endsequence

  property p_start;
    s_master_start |=> s_master_running;
  endproperty
  a_start: assert property (p_start) else $error("master write did not start clocking");
  property p_eight;
    (s.st == ST_MASTER && done && !fault && !cfg_abort) |=> tog_cnt == EDGES_PER_BYTE && s.st == ST_IDLE;
  endproperty
  a_eight: assert property (p_eight) else $error("master byte not sixteen clock edges");
  property p_complete;
    (done && !s.flags.tc && !fault && !cfg_abort) |=> s.flags.tc && s.rbuf == $past(rx_byte);
  endproperty
  a_complete: assert property (p_complete) else $error("received byte not buffered");
  property p_overrun;
    (done && s.flags.tc) |=> s.flags.ovf && $stable(s.rbuf);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged or buffer changed");
  property p_tc_sticky;
    s.flags.tc && !(wr_flags && !BUS_REQ.wdata[FLG_TC]) |=> s.flags.tc;
  endproperty
  a_tc_sticky: assert property (p_tc_sticky) else $error("complete flag lost");
  property p_mode_fault_flag;
    fault |=> !s.ctrl.mst && !s.ctrl.en && s.flags.mode_fault_flag && s.st == ST_IDLE;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not handled");
  property p_write_collision_flag;
    (wr_data && busy && !edge_go && !(s.st == ST_SLAVE && pin_s.ss_n)) |=> s.flags.write_collision_flag && $stable(s.shifter);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");
  property p_cpha0_write_collision_flag;
    (wr_data && slave_on && !s.ctrl.cpha && !pin_s.ss_n) |=> s.flags.write_collision_flag && s.st != ST_MASTER;
  endproperty
  a_cpha0_write_collision_flag: assert property (p_cpha0_write_collision_flag) else $error("selected slave write not a collision");
  property p_abort;
    (s.st == ST_SLAVE && pin_s.ss_n) |=> s.st == ST_IDLE && $stable(s.rbuf);
  endproperty
  a_abort: assert property (p_abort) else $error("slave abort failed");
  property p_cfg;
    cfg_abort |=> s.st == ST_IDLE;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config change did not abort");
  property p_ss_auto;
    (s.st == ST_MASTER && s.ctrl.soe && s.flags.mfd) |-> PIN_OE.ss_n && !PIN_OUT.ss_n;
  endproperty
  a_ss_auto: assert property (p_ss_auto) else $error("auto select not low in transfer");
  property p_idle_sck;
    (s.st != ST_MASTER && s.ctrl.en && s.ctrl.mst) |-> PIN_OUT.sck == s.ctrl.cpol;
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("idle clock level wrong");
  property p_irq;
    (s.flags.tc || s.flags.ovf || s.flags.mode_fault_flag) && !wr_flags && PORT_IRQ_EN && GLOBAL_IRQ_EN |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

//--- verilog/spi_port_pkg.sv
package spi_port_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map and fields.

  localparam logic [7:0] ADDR_CTRL   = 8'hf3;
  localparam logic [7:0] ADDR_FLAGS  = 8'hf4;
  localparam logic [7:0] ADDR_DATA   = 8'hf5;

  localparam int FLG_TC   = 7;
  localparam int FLG_WRITE_COLLISION_FLAG = 6;
  localparam int FLG_OVF  = 5;
  localparam int FLG_MODE_FAULT_FLAG = 4;
  localparam int FLG_MFD  = 3;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.

  localparam logic [6:0] HALF_BASE = 7'h08;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_MASTER = 3'b010,
    ST_SLAVE  = 3'b100
  } mode_state_t;

  typedef struct packed {
    logic       soe;
    logic       en;
    logic       lsb;
    logic       mst;
    logic       cpol;
    logic       cpha;
    logic [1:0] rate;
  } ctrl_t;

  typedef struct packed {
    logic tc;
    logic write_collision_flag;
    logic ovf;
    logic mode_fault_flag;
    logic mfd;
  } flags_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
  } pin_bus_t;

  typedef struct packed {
    mode_state_t st;
    ctrl_t       ctrl;
    flags_t      flags;
    logic [7:0]  shifter;
    logic [7:0]  rbuf;
    logic [7:0]  rdata;
    logic        rx_bit;
    logic [3:0]  edge_cnt;
    logic [6:0]  div_cnt;
    logic        sck;
    logic        sck_prev;
    logic        ss_prev;
    pin_bus_t    pout;
    pin_bus_t    poe;
    logic        irq;
  } port_state_t;

endpackage

//--- verilog/spi_sync2.sv
`timescale 1ns/10ps
module spi_sync2 #(
  parameter int           W    = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input  logic         clk,
  input  logic         rst_n,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  // Stage 0 is the metastable stage; only stage 1 reads it.
  logic [1:0][W-1:0] stage;
  logic [1:0][W-1:0] next_stage;

  always_comb begin
    next_stage[0] = d;
    next_stage[1] = stage[0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage <= {INIT, INIT};
    end else begin
      stage <= next_stage;
    end
  end

  assign q = stage[1];

endmodule
